// ===== core/current_ctrl_pkg.sv
package current_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;         // Core clock period
  localparam int DELAY_UNIT_MS     = 10;         // Power-down delay unit
  localparam int NS_PER_MS         = 1000000;    // Unit conversion
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int LOAD_W   = 10;                  // Load reading width
  localparam int SPEED_W  = 12;                  // Speed magnitude width
  localparam int CODE_W   = 8;                   // Current code width
  localparam int LEVEL_W  = 5;                   // 32 effective levels
  localparam int LEVEL_SH = 3;                   // Eight codes per level
  localparam int DELAY_W  = 16;                  // Power-down delay width
  localparam int DCNT_W   = 6;                   // Down-step reading counter

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CURRENT_CFG_OFS = 8'h00; // Current settings
  localparam logic [7:0] LOAD_CFG_OFS    = 8'h04; // Load thresholds
  localparam logic [7:0] SPEED_CFG_OFS   = 8'h08; // Speed thresholds
  localparam logic [7:0] DELAY_CFG_OFS   = 8'h0C; // Power-down delay
  localparam logic [7:0] STATUS_OFS      = 8'h10; // Block state

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0]       unused;                   // Reads zero
    logic [1:0]        current_up_step;          // Increment code
    logic [1:0]        current_down_step;        // Decrement code
    logic              current_min_sel;          // 0: half, 1: quarter
    logic [CODE_W-1:0] standby_current;          // Standby code
    logic [CODE_W-1:0] absolute_max_current;     // Running code
  } current_cfg_type;

  typedef struct packed {
    logic [11:0]       unused;                   // Reads zero
    logic [LOAD_W-1:0] load_hysteresis;          // Upper minus lower
    logic [LOAD_W-1:0] load_lower;               // Lower threshold
  } load_cfg_type;

  typedef struct packed {
    logic [6:0]         unused;                  // Reads zero
    logic               stall_stop_enable;       // Stop on stall on
    logic [SPEED_W-1:0] stall_stop_speed;        // Stall speed floor
    logic [SPEED_W-1:0] adaptive_threshold_speed; // Regulation speed floor
  } speed_cfg_type;

  typedef struct packed {
    logic [18:0]        unused;                  // Reads zero
    logic               standstill;              // Speed is zero
    logic               stalled;                 // Stopped on stall, W1C
    logic               standby;                 // Standby current applied
    logic [LEVEL_W-1:0] adaptive_level;          // Regulated level
    logic [LEVEL_W-1:0] applied_level;           // Level sent to driver
  } status_type;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam current_cfg_type CURRENT_CFG_RST = '{unused: '0, current_up_step: '0,
    current_down_step: '0, current_min_sel: 1'b0, standby_current: 8'h40,
    absolute_max_current: 8'hFF};
  localparam load_cfg_type  LOAD_CFG_RST  = '{unused: '0, load_hysteresis: 10'h040,
    load_lower: 10'h040};
  localparam speed_cfg_type SPEED_CFG_RST = '{unused: '0, stall_stop_enable: 1'b0,
    stall_stop_speed: 12'h000, adaptive_threshold_speed: 12'h000};
  localparam logic [DELAY_W-1:0] POWER_DOWN_DELAY_RST = 16'h00C8; // 200 units

  // ----------------------------------------------------------------
  // Step tables
  // ----------------------------------------------------------------
  // Readings above the upper threshold per decrement
  function automatic logic [DCNT_W-1:0] down_readings(input logic [1:0] code);
    unique case (code)
      2'h0: down_readings = 6'h20;
      2'h1: down_readings = 6'h08;
      2'h2: down_readings = 6'h02;
      2'h3: down_readings = 6'h01;
    endcase
  endfunction : down_readings

  // Level increment per reading below the lower threshold
  function automatic logic [LEVEL_W:0] up_size(input logic [1:0] code);
    up_size = 6'h01 << code;
  endfunction : up_size

endpackage : current_ctrl_pkg

// ===== core/delay_tick.sv
`timescale 1ns/10ps
module delay_tick
  import current_ctrl_pkg::*;
#(
  parameter int PERIOD = DELAY_UNIT_CYCLES     // Cycles per tick
)
(
  input  wire logic core_clk,                  // Core clock
  input  wire logic reset,                     // Synchronous reset
  input  wire logic run,                       // Count while high
  output logic      tick                       // One-cycle pulse per period
);

  localparam int CNT_W = $clog2(PERIOD + 1);   // Counter width
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1); // Final count

  logic [CNT_W-1:0] cnt_reg;                   // Cycle counter
  logic [CNT_W-1:0] cnt_next;                  // Next count
  logic             tick_reg;                  // Registered pulse
  logic             tick_next;                 // Next pulse

  // ----------------------------------------------------------------
  // Divider, restarted whenever counting is not wanted
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_next  = '0;
    tick_next = 1'b0;
    if (run)
    begin
      if (cnt_reg == LAST)
        tick_next = 1'b1;                      // Period complete
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : delay_tick

// ===== core/load_current_ctrl.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module load_current_ctrl
  import current_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = DELAY_UNIT_CYCLES  // Cycles per delay unit
)
(
  input  wire logic               core_clk,      // 50 MHz clock
  input  wire logic               reset,         // Synchronous, active high
  input  wire logic [7:0]         paddr,         // APB address
  input  wire logic               psel,          // APB select
  input  wire logic               penable,       // APB access phase
  input  wire logic               pwrite,        // APB direction
  input  wire logic [31:0]        pwdata,        // APB write data
  output logic      [31:0]        prdata,        // APB read data
  output logic                    pready,        // APB ready
  output logic                    pslverr,       // APB error, unmapped
  input  wire logic [LOAD_W-1:0]  load_value,    // Load reading
  input  wire logic               load_valid,    // Reading strobe
  input  wire logic [SPEED_W-1:0] motor_speed,   // Speed magnitude
  output logic      [LEVEL_W-1:0] current_level, // Level to driver
  output logic                    standby_active, // Standby current applied
  output logic                    motor_stop     // Stop request on stall
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  current_cfg_type    cur_cfg_reg,  cur_cfg_next;   // Current settings
  load_cfg_type       load_cfg_reg, load_cfg_next;  // Load thresholds
  speed_cfg_type      spd_cfg_reg,  spd_cfg_next;   // Speed thresholds
  logic [DELAY_W-1:0] pd_delay_reg, pd_delay_next;  // Power-down delay
  logic [31:0]        prdata_reg,   prdata_next;    // Read data
  logic               err_reg,      err_next;       // Unmapped flag
  status_type         status;                       // Read view
  status_type         wr_status;                    // Write data as status fields
  logic               mapped;                       // Address decodes
  logic               wr_en;                        // Write takes effect
  logic               stall_clr;                    // Software clears stall

  // Regulation state
  logic [LEVEL_W-1:0] act_reg,  act_next;           // Regulated level
  logic [DCNT_W-1:0]  dcnt_reg, dcnt_next;          // High readings seen
  logic               stall_reg, stall_next;        // Stopped on stall
  logic [DELAY_W-1:0] pd_cnt_reg, pd_cnt_next;      // Standstill units
  logic               stby_reg, stby_next;          // Standby applied
  logic [LEVEL_W-1:0] lvl_reg, lvl_next;            // Applied level

  // Derived values
  logic [LEVEL_W-1:0] run_scale;                    // Running level
  logic [LEVEL_W-1:0] stby_scale;                   // Standby level
  logic [LEVEL_W-1:0] floor_level;                  // Lowest regulated level
  logic [LOAD_W:0]    upper;                        // Upper threshold
  logic               reg_active;                   // Regulation on
  logic               above, below;                 // Reading vs thresholds
  logic               stall_hit;                    // Stall condition
  logic               standstill;                   // Motor not moving
  logic               unit_tick;                    // One delay unit passed
  default clocking cb @(posedge core_clk); endclocking // Checks sample here
  default disable iff (reset);                      // Checks rest in reset

  // Address decode is shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CURRENT_CFG_OFS) || (a == LOAD_CFG_OFS) ||
                (a == SPEED_CFG_OFS) || (a == DELAY_CFG_OFS) || (a == STATUS_OFS);
  endfunction : is_mapped

  assign mapped    = is_mapped(paddr);
  assign wr_en     = psel && penable && pwrite && mapped;
  assign wr_status = status_type'(pwdata);
  assign stall_clr = wr_en && (paddr == STATUS_OFS) && wr_status.stalled;

  // ----------------------------------------------------------------
  // APB slave: zero wait, read data latched in the setup cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_cfg_next  = cur_cfg_reg;
    load_cfg_next = load_cfg_reg;
    spd_cfg_next  = spd_cfg_reg;
    pd_delay_next = pd_delay_reg;
    prdata_next   = prdata_reg;
    err_next      = err_reg;
    if (psel && !penable)
    begin
      // Setup cycle prepares the answer for the access cycle
      err_next = !mapped;
      unique case (paddr)
        CURRENT_CFG_OFS: prdata_next = 32'(cur_cfg_reg);
        LOAD_CFG_OFS:    prdata_next = 32'(load_cfg_reg);
        SPEED_CFG_OFS:   prdata_next = 32'(spd_cfg_reg);
        DELAY_CFG_OFS:   prdata_next = 32'(pd_delay_reg);
        STATUS_OFS:      prdata_next = 32'(status);
        default:         prdata_next = '0;      // Unmapped reads zero
      endcase
    end
    if (wr_en)
    begin
      unique case (paddr)
        CURRENT_CFG_OFS: cur_cfg_next  = current_cfg_type'(pwdata);
        LOAD_CFG_OFS:    load_cfg_next = load_cfg_type'(pwdata);
        SPEED_CFG_OFS:   spd_cfg_next  = speed_cfg_type'(pwdata);
        DELAY_CFG_OFS:   pd_delay_next = pwdata[DELAY_W-1:0];
        default:         ;                      // Status: only the stall clear
      endcase
    end
    // Reserved fields are forced to zero so they read back as zero
    cur_cfg_next.unused  = '0;
    load_cfg_next.unused = '0;
    spd_cfg_next.unused  = '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cur_cfg_reg  <= CURRENT_CFG_RST;
      load_cfg_reg <= LOAD_CFG_RST;
      spd_cfg_reg  <= SPEED_CFG_RST;
      pd_delay_reg <= POWER_DOWN_DELAY_RST;
      prdata_reg   <= '0;
      err_reg      <= 1'b0;
    end
    else
    begin
      cur_cfg_reg  <= cur_cfg_next;
      load_cfg_reg <= load_cfg_next;
      spd_cfg_reg  <= spd_cfg_next;
      pd_delay_reg <= pd_delay_next;
      prdata_reg   <= prdata_next;
      err_reg      <= err_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;

  // ----------------------------------------------------------------
  // Derived levels and comparisons
  // ----------------------------------------------------------------
  // Code 255 lands on the top level; eight codes share one level
  assign run_scale   = cur_cfg_reg.absolute_max_current[CODE_W-1:LEVEL_SH];
  assign stby_scale  = cur_cfg_reg.standby_current[CODE_W-1:LEVEL_SH];
  assign floor_level = cur_cfg_reg.current_min_sel ? (run_scale >> 2) : (run_scale >> 1);
  assign upper       = {1'b0, load_cfg_reg.load_lower}
                     + {1'b0, load_cfg_reg.load_hysteresis};
  assign above       = {1'b0, load_value} > upper;
  assign below       = load_value < load_cfg_reg.load_lower;
  assign reg_active  = motor_speed > spd_cfg_reg.adaptive_threshold_speed;
  // A reading of zero is the maximum-load point
  assign stall_hit   = spd_cfg_reg.stall_stop_enable && load_valid && (load_value == '0) &&
                       (motor_speed > spd_cfg_reg.stall_stop_speed);
  assign standstill  = motor_speed == '0;

  // ----------------------------------------------------------------
  // Adaptive level regulation
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [LEVEL_W:0] sum;                       // Widened increment result
    logic [LEVEL_W-1:0] base;                    // Level clamped to bounds
    sum       = '0;
    base      = act_reg;
    dcnt_next = dcnt_reg;
    // Clamp first so a new scale or floor takes hold at once
    if (base > run_scale)
      base = run_scale;
    else if (base < floor_level)
      base = floor_level;
    act_next = base;
    if (!reg_active)
    begin
      // At or below the threshold speed the full running level applies
      act_next  = run_scale;
      dcnt_next = '0;
    end
    else if (load_valid)
    begin
      if (above)
      begin
        if (dcnt_reg + 1'b1 >= down_readings(cur_cfg_reg.current_down_step))
        begin
          dcnt_next = '0;
          if (base > floor_level)
            act_next = base - 1'b1;
        end
        else
          dcnt_next = dcnt_reg + 1'b1;
      end
      else
      begin
        // Any reading not above the upper threshold breaks the run
        dcnt_next = '0;
        if (below)
        begin
          sum = {1'b0, base} + up_size(cur_cfg_reg.current_up_step);
          if (sum > {1'b0, run_scale})
            act_next = run_scale;
          else
            act_next = sum[LEVEL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      act_reg  <= CURRENT_CFG_RST.absolute_max_current[CODE_W-1:LEVEL_SH];
      dcnt_reg <= '0;
    end
    else
    begin
      act_reg  <= act_next;
      dcnt_reg <= dcnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Stall stop, standstill timer and applied level
  // ----------------------------------------------------------------
  delay_tick #(.PERIOD (TICK_CYCLES)) u_delay_tick (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (standstill),
    .tick     (unit_tick)
  );

  always_comb
  begin
    // A stall in the same cycle as the clear keeps the flag set
    stall_next = stall_hit || (stall_reg && !stall_clr);
    pd_cnt_next = pd_cnt_reg;
    if (!standstill)
      pd_cnt_next = '0;
    else if (unit_tick && pd_cnt_reg != '1)
      pd_cnt_next = pd_cnt_reg + 1'b1;
    stby_next = standstill && (pd_cnt_reg >= pd_delay_reg);
    lvl_next  = stby_next ? stby_scale : act_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stall_reg  <= 1'b0;
      pd_cnt_reg <= '0;
      stby_reg   <= 1'b0;
      lvl_reg    <= '0;
    end
    else
    begin
      stall_reg  <= stall_next;
      pd_cnt_reg <= pd_cnt_next;
      stby_reg   <= stby_next;
      lvl_reg    <= lvl_next;
    end
  end

  assign current_level  = lvl_reg;
  assign standby_active = stby_reg;
  assign motor_stop     = stall_reg;

  // Read view of the live state, reserved bits zero
  assign status = '{unused: '0, standstill: standstill, stalled: stall_reg, standby: stby_reg,
                    adaptive_level: act_reg, applied_level: lvl_reg};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_inactive_full;
    !reg_active |=> act_reg == $past(run_scale);
  endproperty
  a_inactive_full: assert property (p_inactive_full) else $error("level not at full scale");
  // Bounds are those in force when the level was computed
  property p_bounds;
    reg_active && $stable(cur_cfg_reg) |=>
      (act_reg <= $past(run_scale)) && (act_reg >= $past(floor_level));
  endproperty
  a_bounds: assert property (p_bounds) else $error("level outside floor and scale");
  property p_up_step;
    reg_active && load_valid && below && act_reg >= floor_level &&
      ({1'b0, act_reg} + up_size(cur_cfg_reg.current_up_step) <= {1'b0, run_scale})
      |=> act_reg == $past(act_reg) + $past(up_size(cur_cfg_reg.current_up_step));
  endproperty
  a_up_step: assert property (p_up_step) else $error("increment size wrong");
  property p_fast_down;
    reg_active && load_valid && above && cur_cfg_reg.current_down_step == 2'h3 &&
      act_reg > floor_level && act_reg <= run_scale
      |=> act_reg == $past(act_reg) - 1'b1;
  endproperty
  a_fast_down: assert property (p_fast_down) else $error("one reading did not decrement");
  property p_hold_band;
    reg_active && load_valid && !above && !below &&
      act_reg >= floor_level && act_reg <= run_scale |=> $stable(act_reg);
  endproperty
  a_hold_band: assert property (p_hold_band) else $error("level moved inside band");
  property p_slow_down;
    reg_active && load_valid && above && cur_cfg_reg.current_down_step == 2'h0 &&
      dcnt_reg == '0 |=> act_reg >= $past(act_reg) || $past(act_reg) > $past(run_scale);
  endproperty
  a_slow_down: assert property (p_slow_down) else $error("decrement before count reached");
  property p_stall_stop;
    stall_hit |=> motor_stop ##1 (motor_stop || $past(stall_clr));
  endproperty
  a_stall_stop: assert property (p_stall_stop) else $error("stall did not stop motor");
  property p_no_slow_stall;
    !motor_stop && motor_speed <= spd_cfg_reg.stall_stop_speed |=> !motor_stop;
  endproperty
  a_no_slow_stall: assert property (p_no_slow_stall) else $error("stall stop at low speed");
  property p_standby;
    standstill && pd_cnt_reg >= pd_delay_reg |=>
      standby_active && current_level == $past(stby_scale);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not applied after delay");
  property p_run_level;
    !standstill && !reg_active |=>
      current_level == $past(cur_cfg_reg.absolute_max_current) >> LEVEL_SH;
  endproperty
  a_run_level: assert property (p_run_level) else $error("level not code over eight");
  property p_floor;
    reg_active && $stable(cur_cfg_reg) && cur_cfg_reg.current_min_sel |=>
      act_reg >= ($past(run_scale) >> 2);
  endproperty
  a_floor: assert property (p_floor) else $error("level below quarter floor");

endmodule : load_current_ctrl

// ===== testbench/load_adaptive_current_control_test.sv
`timescale 1ns/10ps
module load_adaptive_current_control_test
  import current_ctrl_pkg::*;
;
  logic               core_clk, reset, psel, penable, pwrite, req, err;
  logic               pready, pslverr, load_valid, standby_active, motor_stop;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [LOAD_W-1:0]  req_value, load_value;
  logic [SPEED_W-1:0] motor_speed;
  logic [LEVEL_W-1:0] current_level;
  int                 error_cnt, cmp_count;
  int                 dn[4] = '{32, 8, 2, 1}; // Readings per decrement
  // Short delay unit keeps the standstill wait brief
  load_current_ctrl #(.TICK_CYCLES(10)) uut (.core_clk(core_clk), .reset(reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_value(load_value),
    .load_valid(load_valid), .motor_speed(motor_speed), .current_level(current_level),
    .standby_active(standby_active), .motor_stop(motor_stop));
  load_source src (.core_clk(core_clk), .req(req), .req_value(req_value),
    .load_value(load_value), .load_valid(load_valid));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Send n readings, then let the level settle
  task automatic send(input logic [LOAD_W-1:0] v, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      req       <= 1'b1;
      req_value <= v;
      @(posedge core_clk);
      req <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
  endtask : send
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end
  initial
  begin
    #(CLK_PERIOD_NS * 40000);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    {reset, psel, penable, pwrite, req, paddr, pwdata, req_value} = '0;
    reset = 1'b1;
    motor_speed = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, CURRENT_CFG_OFS, 32'h0);
    chk("current_cfg", rd, 32'h0000_40FF);
    chk("level", current_level, 32'h1F);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // Standby after 200 delay units of standstill
    repeat (1900) @(posedge core_clk);
    #1;
    chk("early standby", standby_active, 32'h0);
    repeat (200) @(posedge core_clk);
    #1;
    chk("standby", standby_active, 32'h1);
    chk("standby level", current_level, 32'h08);
    $display("standby test done");
    apb(1'b1, SPEED_CFG_OFS, 32'h0000_0032);
    apb(1'b1, LOAD_CFG_OFS, {12'h000, 10'h032, 10'h064});
    apb(1'b0, LOAD_CFG_OFS, 32'h0);
    chk("load_cfg", rd, {12'h000, 10'h032, 10'h064});
    apb(1'b1, CURRENT_CFG_OFS, {11'h000, 2'h3, 2'h3, 1'b0, 8'h40, 8'h87});
    motor_speed <= 12'h064;
    send(10'h096, 4);
    chk("at upper", current_level, 32'h10);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, CURRENT_CFG_OFS, {11'h000, 2'(c), 2'(c), 1'b0, 8'h40, 8'h87});
      send(10'h097, dn[c] - 1);
      chk("before step", current_level, 32'h10);
      send(10'h097, 1);
      chk("down step", current_level, 32'h0F);
      send(10'h097, 8 * dn[c]);
      chk("half floor", current_level, 32'h08);
      send(10'h063, 1);
      chk("up step", current_level, 32'(8 + (1 << c)));
      send(10'h063, 8);
      chk("scale cap", current_level, 32'h10);
    end
    apb(1'b1, CURRENT_CFG_OFS, {11'h000, 2'h0, 2'h3, 1'b1, 8'h40, 8'h87});
    send(10'h097, 20);
    chk("quarter floor", current_level, 32'h04);
    motor_speed <= 12'h032;
    send(10'h097, 3);
    chk("unregulated", current_level, 32'h10);
    $display("regulation test done");
    apb(1'b1, SPEED_CFG_OFS, {7'h00, 1'b1, 12'h050, 12'h032});
    motor_speed <= 12'h050;
    send(10'h000, 1);
    chk("no stall stop", motor_stop, 32'h0);
    motor_speed <= 12'h064;
    send(10'h000, 1);
    chk("stall stop", motor_stop, 32'h1);
    apb(1'b1, STATUS_OFS, 32'h0000_0800);
    @(posedge core_clk);
    chk("stall clear", motor_stop, 32'h0);
    $display("stall test done");
    final_report();
  end
endmodule : load_adaptive_current_control_test

// ===== testbench/load_source.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Driver-side load reading source
// ----------------------------------------------------------------
module load_source
  import current_ctrl_pkg::*;
(
  input  wire logic              core_clk,   // Core clock
  input  wire logic              req,        // Send one reading this cycle
  input  wire logic [LOAD_W-1:0] req_value,  // Reading to send
  output logic      [LOAD_W-1:0] load_value, // Reading to the block
  output logic                   load_valid  // Reading strobe
);
  logic [LOAD_W-1:0] last_reg = '0; // Last reading sent
  // Remember the last reading so the idle bus can show its inverse
  always_ff @(posedge core_clk)
  begin
    if (req)
      last_reg <= req_value;
  end
  // Zero means full load; off-strobe the bus never repeats stale data
  assign load_valid = req;
  assign load_value = req ? req_value : ~last_reg;
endmodule : load_source
